// *** masb_pkg.sv ***
// package: register map, field positions and reset values of the alert status bank
package masb_pkg;

   localparam int         MASB_CELLS     = 14;
   localparam int         MASB_AUX       = 6;
   localparam int         MASB_DW        = 16;
   localparam int         MASB_ADDR_W    = 8;
   localparam int         MASB_CODE_W    = 14;

   // register offsets (word addresses)
   localparam logic [7:0] MASB_DIGEST_OFS = 8'h07;
   localparam logic [7:0] MASB_HIGH_OFS   = 8'h08;
   localparam logic [7:0] MASB_LOW_OFS    = 8'h09;

   localparam logic [15:0] MASB_RST_VAL   = 16'h0000;

   // alert digest bit positions
   localparam int MASB_B_ADC_CELL_HIGH = 15;
   localparam int MASB_B_CMP_CELL_HIGH = 14;
   localparam int MASB_B_ADC_CELL_LOW  = 13;
   localparam int MASB_B_CMP_CELL_LOW  = 12;
   localparam int MASB_B_ADC_AUX_COLD  = 11;
   localparam int MASB_B_CMP_AUX_COLD  = 10;
   localparam int MASB_B_ADC_AUX_HOT   = 9;
   localparam int MASB_B_CMP_AUX_HOT   = 8;
   localparam int MASB_B_CHG_HIGH      = 7;
   localparam int MASB_B_DSG_HIGH      = 6;
   localparam int MASB_B_CAL_OS_ADC    = 4;
   localparam int MASB_B_CAL_OS_RAMP   = 3;
   localparam int MASB_B_CAL_OS_RATIO  = 2;
   localparam int MASB_B_CAL_GAIN_PYR  = 1;
   localparam int MASB_B_CAL_GAIN_RAMP = 0;

   // calibration kinds, index into the calibration fault vector
   localparam int MASB_NCAL            = 5;

endpackage : masb_pkg

// *** masb_alert_bank.sv ***
// alert status bank: cell, aux, current and calibration alerts with a read-only register port
`timescale 1ns/100ps

module masb_alert_bank
   import masb_pkg::*;
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     resetn,
   // register port
   input  wire logic [MASB_ADDR_W-1:0]   reg_addr,
   input  wire logic [MASB_DW-1:0]       reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic      [MASB_DW-1:0]       reg_rdata,
   // cell acquisition result, one pulse per cell set
   input  wire logic                     cell_acq_done,
   input  wire logic [MASB_CELLS*MASB_CODE_W-1:0] cell_codes,
   input  wire logic [MASB_CELLS-1:0]    cell_polarity,
   input  wire logic [MASB_CELLS-1:0]    cell_high_check_enable,
   input  wire logic [MASB_CELLS-1:0]    cell_low_check_enable,
   input  wire logic [MASB_CODE_W-1:0]   unipolar_high_limit,
   input  wire logic [MASB_CODE_W-1:0]   bipolar_high_limit,
   input  wire logic [MASB_CODE_W-1:0]   unipolar_low_limit,
   input  wire logic [MASB_CODE_W-1:0]   bipolar_low_limit,
   // per-channel flags from comparator and aux checkers, valid with cell_acq_done
   input  wire logic [MASB_CELLS-1:0]    cmp_cell_high_flags,
   input  wire logic [MASB_CELLS-1:0]    cmp_cell_low_flags,
   input  wire logic [MASB_AUX-1:0]      aux_cold_flags,
   input  wire logic [MASB_AUX-1:0]      cmp_aux_cold_flags,
   input  wire logic [MASB_AUX-1:0]      aux_hot_flags,
   input  wire logic [MASB_AUX-1:0]      cmp_aux_hot_flags,
   // current-sense acquisition
   input  wire logic                     csa_acq_done,
   input  wire logic [MASB_CODE_W-1:0]   csa_code,
   input  wire logic [MASB_CODE_W-1:0]   charge_current_limit,
   input  wire logic [MASB_CODE_W-1:0]   discharge_current_limit,
   // calibration results: one done pulse and one out-of-bounds bit per kind
   input  wire logic [MASB_NCAL-1:0]     cal_done,
   input  wire logic [MASB_NCAL-1:0]     cal_out_of_bounds,
   // status view
   output logic [MASB_CELLS-1:0]         cell_high_flags,
   output logic [MASB_CELLS-1:0]         cell_low_flags,
   output logic [MASB_DW-1:0]            alert_digest
);

   // ==========================================================
   // per-cell threshold compare
   logic [MASB_CELLS-1:0] high_hit;
   logic [MASB_CELLS-1:0] low_hit;

   // codes are compared as signed two's complement so bipolar cells
   // work; unipolar limits are positive so the same compare holds
   for (genvar i = 0; i < MASB_CELLS; i++) begin : g_cell
      logic signed [MASB_CODE_W-1:0] code;
      logic signed [MASB_CODE_W-1:0] hlim;
      logic signed [MASB_CODE_W-1:0] llim;
      assign code = cell_codes[i*MASB_CODE_W +: MASB_CODE_W];
      assign hlim = cell_polarity[i] ? bipolar_high_limit : unipolar_high_limit;
      assign llim = cell_polarity[i] ? bipolar_low_limit : unipolar_low_limit;
      assign high_hit[i] = cell_high_check_enable[i] && (code > hlim);
      assign low_hit[i]  = cell_low_check_enable[i] && (code < llim);
   end

   // ==========================================================
   // per-cell flag vectors
   logic [MASB_CELLS-1:0] cell_high_flags_r;
   logic [MASB_CELLS-1:0] cell_low_flags_r;
   logic [MASB_CELLS-1:0] cell_high_flags_nxt;
   logic [MASB_CELLS-1:0] cell_low_flags_nxt;

   // each acquisition replaces the whole vector instead of or-ing into it,
   // so a cell whose condition is resolved clears on that same result;
   // between acquisitions the vectors hold, whatever the inputs do
   always_comb begin
      cell_high_flags_nxt = cell_high_flags_r;
      cell_low_flags_nxt  = cell_low_flags_r;
      if (cell_acq_done) begin
         cell_high_flags_nxt = high_hit;
         cell_low_flags_nxt  = low_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cell_high_flags_r <= '0;
         cell_low_flags_r  <= '0;
      end else begin
         cell_high_flags_r <= cell_high_flags_nxt;
         cell_low_flags_r  <= cell_low_flags_nxt;
      end
   end

   // ==========================================================
   // channel digest bits
   logic [7:0] chan_any;
   logic [7:0] chan_digest_r;
   logic [7:0] chan_digest_nxt;

   // the adc cell bits come from the fresh compare, not from the flag
   // registers, so a digest bit and its flag vector move on one edge
   always_comb begin
      chan_any                         = 8'h00;
      chan_any[MASB_B_ADC_CELL_HIGH-8] = |high_hit;
      chan_any[MASB_B_CMP_CELL_HIGH-8] = |cmp_cell_high_flags;
      chan_any[MASB_B_ADC_CELL_LOW-8]  = |low_hit;
      chan_any[MASB_B_CMP_CELL_LOW-8]  = |cmp_cell_low_flags;
      chan_any[MASB_B_ADC_AUX_COLD-8]  = |aux_cold_flags;
      chan_any[MASB_B_CMP_AUX_COLD-8]  = |cmp_aux_cold_flags;
      chan_any[MASB_B_ADC_AUX_HOT-8]   = |aux_hot_flags;
      chan_any[MASB_B_CMP_AUX_HOT-8]   = |cmp_aux_hot_flags;
   end

   // a summary bit only clears when no contributing condition remains;
   // disabled cells already read as resolved in high_hit and low_hit
   always_comb begin
      chan_digest_nxt = chan_digest_r;
      if (cell_acq_done) begin
         chan_digest_nxt = chan_any;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         chan_digest_r <= '0;
      end else begin
         chan_digest_r <= chan_digest_nxt;
      end
   end

   // ==========================================================
   // current-sense alerts
   logic signed [MASB_CODE_W-1:0] csa_val;
   logic signed [MASB_CODE_W-1:0] chg_lim;
   logic signed [MASB_CODE_W-1:0] dsg_lim;
   logic                          charge_hit;
   logic                          discharge_hit;
   logic                          charge_current_high_flag_r;
   logic                          discharge_current_high_flag_r;
   logic                          charge_current_high_flag_nxt;
   logic                          discharge_current_high_flag_nxt;

   // charge current reads positive and discharge negative, so both
   // limits are compared signed; equality to a limit is not an alert
   assign csa_val       = csa_code;
   assign chg_lim       = charge_current_limit;
   assign dsg_lim       = discharge_current_limit;
   assign charge_hit    = csa_val > chg_lim;
   assign discharge_hit = csa_val < dsg_lim;

   // only a current-sense result moves these; cell acquisitions do not
   always_comb begin
      charge_current_high_flag_nxt    = charge_current_high_flag_r;
      discharge_current_high_flag_nxt = discharge_current_high_flag_r;
      if (csa_acq_done) begin
         charge_current_high_flag_nxt    = charge_hit;
         discharge_current_high_flag_nxt = discharge_hit;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         charge_current_high_flag_r    <= 1'b0;
         discharge_current_high_flag_r <= 1'b0;
      end else begin
         charge_current_high_flag_r    <= charge_current_high_flag_nxt;
         discharge_current_high_flag_r <= discharge_current_high_flag_nxt;
      end
   end

   // ==========================================================
   // calibration faults; a software rewrite of a value is reported
   // by the calibration engine as another cal_done with its check,
   // so this block needs no path from the register write port
   logic [MASB_NCAL-1:0] cal_fault_r;
   logic [MASB_NCAL-1:0] cal_fault_nxt;

   for (genvar k = 0; k < MASB_NCAL; k++) begin : g_cal
      // a fault stands until a later result for the same kind
      assign cal_fault_nxt[k] = cal_done[k] ? cal_out_of_bounds[k]
                                            : cal_fault_r[k];

      always_ff @(posedge clk) begin
         if (!resetn) begin
            cal_fault_r[k] <= 1'b0;
         end else begin
            cal_fault_r[k] <= cal_fault_nxt[k];
         end
      end
   end

   // ==========================================================
   // digest assembly
   // layout of the digest word:
   //    15 adc cell high        14 comparator cell high
   //    13 adc cell low         12 comparator cell low
   //    11 adc aux cold         10 comparator aux cold
   //     9 adc aux hot           8 comparator aux hot
   //     7 charge current high   6 discharge current high
   //     5 unused, reads zero
   //     4 adc offset cal fault  3 ramp offset cal fault
   //     2 ratiometric offset    1 pyramid gain
   //     0 ramp gain
   logic [MASB_DW-1:0] digest;

   always_comb begin
      digest                       = MASB_RST_VAL;
      digest[15:8]                 = chan_digest_r;
      digest[MASB_B_CHG_HIGH]      = charge_current_high_flag_r;
      digest[MASB_B_DSG_HIGH]      = discharge_current_high_flag_r;
      digest[MASB_B_CAL_OS_ADC]    = cal_fault_r[4];
      digest[MASB_B_CAL_OS_RAMP]   = cal_fault_r[3];
      digest[MASB_B_CAL_OS_RATIO]  = cal_fault_r[2];
      digest[MASB_B_CAL_GAIN_PYR]  = cal_fault_r[1];
      digest[MASB_B_CAL_GAIN_RAMP] = cal_fault_r[0];
   end

   // ==========================================================
   // register read port; writes are accepted and dropped
   logic [MASB_DW-1:0] reg_rdata_r;
   logic [MASB_DW-1:0] rd_sel;
   logic [MASB_DW-1:0] rd_nxt;

   // unmapped addresses read zero rather than aliasing a register
   always_comb begin
      unique case (reg_addr)
         MASB_DIGEST_OFS: rd_sel = digest;
         MASB_HIGH_OFS:   rd_sel = {2'h0, cell_high_flags_r};
         MASB_LOW_OFS:    rd_sel = {2'h0, cell_low_flags_r};
         default:         rd_sel = MASB_RST_VAL;
      endcase
   end

   // read data stand for one cycle only, so a master that samples late
   // sees zero instead of stale data
   always_comb begin
      rd_nxt = MASB_RST_VAL;
      if (reg_rd) begin
         rd_nxt = rd_sel;
      end
   end

   // reg_wr and reg_wdata are intentionally not decoded: every register
   // here is status, and no write path reaches any flag
   always_ff @(posedge clk) begin
      if (!resetn) begin
         reg_rdata_r <= MASB_RST_VAL;
      end else begin
         reg_rdata_r <= rd_nxt;
      end
   end

   // ==========================================================
   // status outputs
   // the digest output trails the readable digest by one cycle; it is
   // registered so the port comes straight from a flip-flop
   logic [MASB_DW-1:0] alert_digest_r;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         alert_digest_r <= MASB_RST_VAL;
      end else begin
         alert_digest_r <= digest;
      end
   end

   assign reg_rdata       = reg_rdata_r;
   assign alert_digest    = alert_digest_r;
   assign cell_high_flags = cell_high_flags_r;
   assign cell_low_flags  = cell_low_flags_r;

endmodule : masb_alert_bank

// *** masb_alert_bank_chk.sv ***
// checker: port assertions for the alert status bank
`timescale 1ns/100ps
module masb_alert_bank_chk
   import masb_pkg::*;
(
   // clock, reset and register port
   input wire logic                   clk,
   input wire logic                   resetn,
   input wire logic [MASB_ADDR_W-1:0] reg_addr,
   input wire logic                   reg_rd,
   input wire logic [MASB_DW-1:0]     reg_rdata,
   // acquisition and status
   input wire logic                   cell_acq_done,
   input wire logic [MASB_CELLS-1:0]  cell_high_check_enable,
   input wire logic [MASB_CELLS-1:0]  cell_high_flags,
   input wire logic [MASB_CELLS-1:0]  cell_low_flags,
   input wire logic [MASB_DW-1:0]     alert_digest
);
   // ====
   // properties: the readback samples state, so reads compare against the previous cycle
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_high_read: assert property (reg_rd && reg_addr == MASB_HIGH_OFS |=>
      reg_rdata == {2'b00, $past(cell_high_flags)}) else $error("cell high read wrong");
   a_low_read: assert property (reg_rd && reg_addr == MASB_LOW_OFS |=>
      reg_rdata == {2'b00, $past(cell_low_flags)}) else $error("cell low read wrong");
   a_digest_high: assert property (alert_digest[15] == |$past(cell_high_flags))
      else $error("digest bit 15 wrong");
   a_digest_low: assert property (alert_digest[13] == |$past(cell_low_flags))
      else $error("digest bit 13 wrong");
   a_cell_disabled: assert property (cell_acq_done && !cell_high_check_enable[1] |=>
      !cell_high_flags[1]) else $error("disabled cell flagged");
   a_all_disabled: assert property (cell_acq_done && cell_high_check_enable == 14'h0000 |=>
      cell_high_flags == 14'h0000 ##1 !alert_digest[15]) else $error("digest not cleared");
   a_flags_hold: assert property (!cell_acq_done |=>
      $stable(cell_high_flags) && $stable(cell_low_flags)) else $error("flags moved");
endmodule : masb_alert_bank_chk

bind masb_alert_bank masb_alert_bank_chk i_chk (.clk, .resetn, .reg_addr, .reg_rd, .reg_rdata,
   .cell_acq_done, .cell_high_check_enable, .cell_high_flags, .cell_low_flags, .alert_digest);

// *** masb_alert_bank_tb.sv ***
// testbench: random acquisitions checked through register reads and the digest output
`timescale 1ns/100ps
module masb_alert_bank_tb
   import masb_pkg::*;
();
   logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic rd_pend, cell_acq_done, csa_acq_done;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, alert_digest, dexp = 16'h0000;
   logic [195:0] cell_codes;
   logic [13:0] cell_polarity, cell_high_check_enable, cell_low_check_enable, cell_high_flags;
   logic [13:0] cell_low_flags, cmp_cell_high_flags, cmp_cell_low_flags, eh = '0, el = '0;
   logic [13:0] unipolar_high_limit, bipolar_high_limit, unipolar_low_limit, bipolar_low_limit;
   logic [13:0] csa_code, charge_current_limit, discharge_current_limit;
   logic [5:0] aux_cold_flags, cmp_aux_cold_flags, aux_hot_flags, cmp_aux_hot_flags;
   logic [4:0] cal_done, cal_out_of_bounds;
   logic signed [13:0] c, lh, ll;
   logic [15:0] q[$];
   int fails = 0, cmp_count = 0, seed = 32'hdf9b8d55;
   masb_alert_bank i_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .cell_acq_done, .cell_codes, .cell_polarity, .cell_high_check_enable, .cell_low_check_enable,
      .unipolar_high_limit, .bipolar_high_limit, .unipolar_low_limit, .bipolar_low_limit,
      .cmp_cell_high_flags, .cmp_cell_low_flags, .aux_cold_flags, .cmp_aux_cold_flags,
      .aux_hot_flags, .cmp_aux_hot_flags, .csa_acq_done, .csa_code, .charge_current_limit,
      .discharge_current_limit, .cal_done, .cal_out_of_bounds, .cell_high_flags,
      .cell_low_flags, .alert_digest);
   initial forever #25 clk = ~clk;
   // ====
   // checking: read data stands only in the cycle after the strobe
   always @(posedge clk) rd_pend <= reg_rd;
   always @(negedge clk) if (rd_pend === 1'b1) chk("reg_rdata", reg_rdata, q.pop_front());
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      fails += int'(got !== exp);
      if (got !== exp) $display("Error %s expected %h seen %h", nm, exp, got);
   endtask : chk
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (3000) @(posedge clk);
      fails++;
      end_of_test;
   end
   // ====
   // stimulus
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, 16'($random(seed))};
      if (!w) q.push_back(e);
      @(posedge clk);
      {reg_wr, reg_rd} <= 2'b00;
   endtask : bus
   // sparse bits so that digest bits clear about as often as they set
   function automatic logic [31:0] sp();
      return $random(seed) & $random(seed) & $random(seed);
   endfunction : sp
   task automatic stim(input logic go);
      for (int i = 0; i < MASB_CELLS; i++) cell_codes[i*14 +: 14] <= 14'($random(seed));
      {cell_polarity, csa_code} <= 28'($random(seed));
      {cell_high_check_enable, cell_low_check_enable} <= 28'(sp());
      {cmp_cell_high_flags, cmp_cell_low_flags} <= 28'(sp());
      {aux_cold_flags, cmp_aux_cold_flags, aux_hot_flags, cmp_aux_hot_flags} <= 24'(sp());
      {unipolar_high_limit, bipolar_high_limit} <= 28'($random(seed));
      {unipolar_low_limit, bipolar_low_limit} <= 28'($random(seed));
      {charge_current_limit, discharge_current_limit} <= 28'($random(seed));
      {cell_acq_done, csa_acq_done, cal_done, cal_out_of_bounds} <= go ? 12'($random(seed)) : 12'h0;
   endtask : stim
   initial begin
      stim(1'b0);
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (41) begin
         bus(1'b0, MASB_DIGEST_OFS, dexp);
         bus(1'b0, MASB_HIGH_OFS, {2'b00, eh});
         bus(1'b0, MASB_LOW_OFS, {2'b00, el});
         bus(1'b0, 8'h0a, 16'h0000);
         @(negedge clk);
         chk("alert_digest", alert_digest, dexp);
         chk("cell_high_flags", {2'b00, cell_high_flags}, {2'b00, eh});
         chk("cell_low_flags", {2'b00, cell_low_flags}, {2'b00, el});
         bus(1'b1, MASB_DIGEST_OFS + 8'($random(seed) & 3), 16'h0000);
         stim(1'b1);
         @(posedge clk);
         if (cell_acq_done) begin
            for (int i = 0; i < MASB_CELLS; i++) begin
               c = cell_codes[i*14 +: 14];
               {lh, ll} = cell_polarity[i] ? {bipolar_high_limit, bipolar_low_limit}
                  : {unipolar_high_limit, unipolar_low_limit};
               eh[i] = cell_high_check_enable[i] && c > lh;
               el[i] = cell_low_check_enable[i] && c < ll;
            end
            dexp[15:8] = {|eh, |cmp_cell_high_flags, |el, |cmp_cell_low_flags, |aux_cold_flags,
               |cmp_aux_cold_flags, |aux_hot_flags, |cmp_aux_hot_flags};
         end
         if (csa_acq_done) dexp[7:6] = {$signed(csa_code) > $signed(charge_current_limit),
            $signed(csa_code) < $signed(discharge_current_limit)};
         for (int k = 0; k < MASB_NCAL; k++)
            if (cal_done[k]) dexp[k] = cal_out_of_bounds[k];
         stim(1'b0);
      end
      $display("acquisition and register test done");
      end_of_test;
   end
endmodule : masb_alert_bank_tb
